//--- logic/origin_cfg_pkg.sv
// Package with register map, field layout and timing constants of the origin search configuration block.
package origin_cfg_pkg;

  // ----------------------------------------------------------------------------------------------
  // Register indices and bus geometry
  // ----------------------------------------------------------------------------------------------
  localparam int unsigned ADDR_W           = 12;
  localparam logic [9:0] IDX_PROX_LO       = 10'h118;
  localparam logic [9:0] IDX_PROX_HI       = 10'h119;
  localparam logic [9:0] IDX_COMP_LO       = 10'h11a;
  localparam logic [9:0] IDX_COMP_HI       = 10'h11b;
  localparam logic [9:0] IDX_ACCEL         = 10'h11c;
  localparam logic [9:0] IDX_DECEL         = 10'h11d;
  localparam logic [9:0] IDX_POLARITY      = 10'h11e;
  localparam logic [9:0] IDX_INIT_LO       = 10'h114;
  localparam logic [9:0] IDX_INIT_HI       = 10'h115;
  localparam logic [9:0] IDX_CONTROL       = 10'h120;
  localparam logic [9:0] IDX_STATUS        = 10'h121;

  // ----------------------------------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------------------------------
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [31:0] SPEED_MIN        = 32'h0000_0001;
  localparam logic [31:0] SPEED_MAX        = 32'h0001_86a0;
  localparam logic [15:0] RATE_MIN         = 16'h0001;
  localparam logic [15:0] RATE_MAX_OLD     = 16'h07d0;
  localparam logic [15:0] RATE_MAX_V2      = 16'hffff;

  // ----------------------------------------------------------------------------------------------
  // Polarity field positions and codes
  // ----------------------------------------------------------------------------------------------
  localparam int unsigned LIMIT_LSB        = 0;
  localparam int unsigned PROX_LSB         = 4;
  localparam int unsigned ORIGIN_LSB       = 8;
  localparam logic [3:0]  POL_NC           = 4'h0;
  localparam logic [3:0]  POL_NO           = 4'h1;

  // ----------------------------------------------------------------------------------------------
  // Control and status bits
  // ----------------------------------------------------------------------------------------------
  localparam int unsigned CTRL_START_BIT   = 0;
  localparam int unsigned CTRL_STOP_BIT    = 1;
  localparam int unsigned CTRL_V2_BIT      = 2;
  localparam int unsigned STAT_RUN_BIT     = 0;
  localparam int unsigned STAT_BAD_BIT     = 1;

  // ----------------------------------------------------------------------------------------------
  // Rate tick timing
  // ----------------------------------------------------------------------------------------------
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned RATE_PERIOD_MS   = 4;
  localparam int unsigned RATE_TICK_CYCLES = CLK_HZ / 1000 * RATE_PERIOD_MS;

  typedef struct packed {
    logic [31:0] init_speed;
    logic [31:0] prox_speed;
    logic [31:0] compensation;
    logic [15:0] accel;
    logic [15:0] decel;
    logic        limit_no;
    logic        prox_no;
    logic        origin_no;
  } search_cfg_t;

  typedef struct packed {
    logic limit;
    logic prox;
    logic origin;
  } sensor_t;

endpackage : origin_cfg_pkg

//--- logic/rate_tick.sv
// Tick generator, held at zero while run_i is low, marking each acceleration or deceleration step.
`timescale 1ns/1ps
module rate_tick #(
  parameter int unsigned PERIOD = origin_cfg_pkg::RATE_TICK_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic run_i,
  output logic      tick_o
);

  localparam int unsigned CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else if (!run_i || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick_o = run_i && (cnt_q == LAST);

endmodule : rate_tick

//--- logic/sensor_polarity.sv
// Converts raw sensor levels to asserted flags using the latched contact type.
`timescale 1ns/1ps
module sensor_polarity (
  input  wire logic                    clk_i,
  input  wire logic                    arst_n_i,
  input  origin_cfg_pkg::sensor_t      raw_i,
  input  origin_cfg_pkg::sensor_t      no_i,
  output origin_cfg_pkg::sensor_t      active_o
);

  // A normally closed contact reads asserted when its raw level is low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_o <= '0;
    end else begin
      active_o <= ~(raw_i ^ no_i);
    end
  end

endmodule : sensor_polarity

//--- logic/origin_search_cfg.sv
// Register store and latched profile generator for the origin search of pulse output one.
//
// Notes on behaviour
// - Proximity speed: two words, 1 to 100000
// - Signed 32-bit origin compensation, full range
// - Acceleration: frequency increment each 4 ms
// - Deceleration: frequency decrement each 4 ms
// - Limit polarity bits 0-3, 0 closed, 1 open
// - Proximity polarity bits 4-7, default closed
// - Origin polarity bits 8-11, default closed
// - Initial speed starts search and return moves
`timescale 1ns/1ps
module origin_search_cfg #(
  parameter int unsigned TICK_CYCLES = origin_cfg_pkg::RATE_TICK_CYCLES
) (
  input  wire logic                              CLK_I,
  input  wire logic                              ARST_N_I,
  input  wire logic [origin_cfg_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input  wire logic                              AVS_READ_I,
  input  wire logic                              AVS_WRITE_I,
  input  wire logic [31:0]                       AVS_WRITEDATA_I,
  input  wire logic [3:0]                        AVS_BYTEENABLE_I,
  output logic [31:0]                            AVS_READDATA_O,
  output logic                                   AVS_WAITREQUEST_O,
  input  wire logic                              LIMIT_IN_I,
  input  wire logic                              PROX_IN_I,
  input  wire logic                              ORIGIN_IN_I,
  output logic                                   LIMIT_ACTIVE_O,
  output logic                                   PROX_ACTIVE_O,
  output logic                                   ORIGIN_ACTIVE_O,
  output logic [31:0]                            FREQ_O,
  output logic [31:0]                            COMPENSATION_O,
  output logic                                   RUNNING_O
);

  // ----------------------------------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------------------------------
  logic [15:0] prox_lo_q;
  logic [15:0] prox_hi_q;
  logic [15:0] comp_lo_q;
  logic [15:0] comp_hi_q;
  logic [15:0] accel_q;
  logic [15:0] decel_q;
  logic [15:0] pol_q;
  logic [15:0] init_lo_q;
  logic [15:0] init_hi_q;
  logic        v2_q;
  logic        ack_q;
  logic        run_q;
  logic        bad_q;
  logic [31:0] freq_q;
  logic [31:0] rdata_d;
  origin_cfg_pkg::search_cfg_t cfg_q;
  origin_cfg_pkg::search_cfg_t cfg_d;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACCEL,
    ST_CRUISE,
    ST_DECEL
  } phase_t;
  phase_t phase_q;

  // ----------------------------------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------------------------------
  logic       word_ok;
  logic [9:0] idx;
  logic       req;
  logic       wr_go;
  logic       rd_go;
  logic       start_req;
  logic       stop_req;

  assign word_ok = (AVS_ADDRESS_I[1:0] == 2'h0);
  assign idx     = AVS_ADDRESS_I[origin_cfg_pkg::ADDR_W-1:2];
  assign req     = AVS_READ_I || AVS_WRITE_I;
  assign wr_go   = AVS_WRITE_I && ack_q;
  assign rd_go   = AVS_READ_I && ack_q;

  // One wait cycle per access; the request is taken on the second edge.
  assign AVS_WAITREQUEST_O = req && !ack_q;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge

  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = wr_go && word_ok && (a == r);
  endfunction : hit

  assign start_req = wr_go && word_ok && (idx == origin_cfg_pkg::IDX_CONTROL) && AVS_BYTEENABLE_I[0]
                     && AVS_WRITEDATA_I[origin_cfg_pkg::CTRL_START_BIT];
  assign stop_req  = wr_go && word_ok && (idx == origin_cfg_pkg::IDX_CONTROL) && AVS_BYTEENABLE_I[0]
                     && AVS_WRITEDATA_I[origin_cfg_pkg::CTRL_STOP_BIT];

  // ----------------------------------------------------------------------------------------------
  // Speed words
  // ----------------------------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prox_lo_q <= origin_cfg_pkg::WORD_RESET;
      prox_hi_q <= origin_cfg_pkg::WORD_RESET;
      init_lo_q <= origin_cfg_pkg::WORD_RESET;
      init_hi_q <= origin_cfg_pkg::WORD_RESET;
    end else begin
      if (hit(idx, origin_cfg_pkg::IDX_PROX_LO)) begin
        prox_lo_q <= merge(prox_lo_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_PROX_HI)) begin
        prox_hi_q <= merge(prox_hi_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_INIT_LO)) begin
        init_lo_q <= merge(init_lo_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_INIT_HI)) begin
        init_hi_q <= merge(init_hi_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end
  end

  // ----------------------------------------------------------------------------------------------
  // Compensation words
  // ----------------------------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      comp_lo_q <= origin_cfg_pkg::WORD_RESET;
      comp_hi_q <= origin_cfg_pkg::WORD_RESET;
    end else begin
      if (hit(idx, origin_cfg_pkg::IDX_COMP_LO)) begin
        comp_lo_q <= merge(comp_lo_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_COMP_HI)) begin
        comp_hi_q <= merge(comp_hi_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end
  end

  // ----------------------------------------------------------------------------------------------
  // Rates, polarity and control
  // ----------------------------------------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      accel_q <= origin_cfg_pkg::WORD_RESET;
      decel_q <= origin_cfg_pkg::WORD_RESET;
      pol_q   <= origin_cfg_pkg::WORD_RESET;
      v2_q    <= 1'b0;
    end else begin
      if (hit(idx, origin_cfg_pkg::IDX_ACCEL)) begin
        accel_q <= merge(accel_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_DECEL)) begin
        decel_q <= merge(decel_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_POLARITY)) begin
        pol_q <= merge(pol_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
      if (hit(idx, origin_cfg_pkg::IDX_CONTROL) && AVS_BYTEENABLE_I[0]) begin
        v2_q <= AVS_WRITEDATA_I[origin_cfg_pkg::CTRL_V2_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------------------------------
  // Validation and latch at start
  // ----------------------------------------------------------------------------------------------
  function automatic logic speed_ok(input logic [31:0] s, input logic [31:0] lo);
    speed_ok = (s >= lo) && (s <= origin_cfg_pkg::SPEED_MAX);
  endfunction : speed_ok

  function automatic logic rate_ok(input logic [15:0] r, input logic v2);
    rate_ok = (r >= origin_cfg_pkg::RATE_MIN)
              && (v2 ? (r <= origin_cfg_pkg::RATE_MAX_V2) : (r <= origin_cfg_pkg::RATE_MAX_OLD));
  endfunction : rate_ok

  function automatic logic is_no(input logic [3:0] code);
    is_no = (code == origin_cfg_pkg::POL_NO);
  endfunction : is_no

  logic settings_ok;

  assign settings_ok = speed_ok({prox_hi_q, prox_lo_q}, origin_cfg_pkg::SPEED_MIN)
                       && speed_ok({init_hi_q, init_lo_q}, 32'h0000_0000)
                       && rate_ok(accel_q, v2_q)
                       && rate_ok(decel_q, v2_q);

  always_comb begin
    cfg_d              = cfg_q;
    cfg_d.init_speed   = {init_hi_q, init_lo_q};
    cfg_d.prox_speed   = {prox_hi_q, prox_lo_q};
    cfg_d.compensation = {comp_hi_q, comp_lo_q};
    cfg_d.accel        = accel_q;
    cfg_d.decel        = decel_q;
    cfg_d.limit_no     = is_no(pol_q[origin_cfg_pkg::LIMIT_LSB +: 4]);
    cfg_d.prox_no      = is_no(pol_q[origin_cfg_pkg::PROX_LSB +: 4]);
    cfg_d.origin_no    = is_no(pol_q[origin_cfg_pkg::ORIGIN_LSB +: 4]);
  end

  logic launch;
  assign launch = start_req && !run_q && settings_ok;

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cfg_q <= '0;
    end else if (launch) begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bad_q <= 1'b0;
    end else if (start_req && !run_q) begin
      bad_q <= !settings_ok;
    end
  end

  // ----------------------------------------------------------------------------------------------
  // Speed profile
  // ----------------------------------------------------------------------------------------------
  logic tick;

  rate_tick #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .run_i    (run_q),
    .tick_o   (tick)
  );

  logic [31:0] up_sum;
  logic [31:0] floor;
  assign up_sum = freq_q + {16'h0000, cfg_q.accel};
  assign floor  = cfg_q.init_speed + {16'h0000, cfg_q.decel};

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      phase_q <= ST_IDLE;
      freq_q  <= '0;
      run_q   <= 1'b0;
    end else begin
      unique case (phase_q)
        ST_IDLE: begin
          if (launch) begin
            phase_q <= ST_ACCEL;
            freq_q  <= cfg_d.init_speed;
            run_q   <= 1'b1;
          end
        end
        ST_ACCEL: begin
          if (stop_req) begin
            phase_q <= ST_DECEL;
          end else if (tick) begin
            if (up_sum >= cfg_q.prox_speed) begin
              freq_q  <= cfg_q.prox_speed;
              phase_q <= ST_CRUISE;
            end else begin
              freq_q <= up_sum;
            end
          end
        end
        ST_CRUISE: begin
          if (stop_req) begin
            phase_q <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (tick) begin
            if (freq_q <= floor) begin
              freq_q  <= '0;
              phase_q <= ST_IDLE;
              run_q   <= 1'b0;
            end else begin
              freq_q <= freq_q - {16'h0000, cfg_q.decel};
            end
          end
        end
      endcase
    end
  end

  assign FREQ_O         = freq_q;
  assign COMPENSATION_O = cfg_q.compensation;
  assign RUNNING_O      = run_q;

  // ----------------------------------------------------------------------------------------------
  // Sensors
  // ----------------------------------------------------------------------------------------------
  origin_cfg_pkg::sensor_t raw;
  origin_cfg_pkg::sensor_t pol_no;
  origin_cfg_pkg::sensor_t act;

  assign raw    = '{limit: LIMIT_IN_I, prox: PROX_IN_I, origin: ORIGIN_IN_I};
  assign pol_no = '{limit: cfg_q.limit_no, prox: cfg_q.prox_no, origin: cfg_q.origin_no};

  sensor_polarity u_pol (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .raw_i    (raw),
    .no_i     (pol_no),
    .active_o (act)
  );

  assign LIMIT_ACTIVE_O  = act.limit;
  assign PROX_ACTIVE_O   = act.prox;
  assign ORIGIN_ACTIVE_O = act.origin;

  // ----------------------------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (word_ok) begin
      unique case (idx)
        origin_cfg_pkg::IDX_PROX_LO:  rdata_d = {16'h0000, prox_lo_q};
        origin_cfg_pkg::IDX_PROX_HI:  rdata_d = {16'h0000, prox_hi_q};
        origin_cfg_pkg::IDX_COMP_LO:  rdata_d = {16'h0000, comp_lo_q};
        origin_cfg_pkg::IDX_COMP_HI:  rdata_d = {16'h0000, comp_hi_q};
        origin_cfg_pkg::IDX_ACCEL:    rdata_d = {16'h0000, accel_q};
        origin_cfg_pkg::IDX_DECEL:    rdata_d = {16'h0000, decel_q};
        origin_cfg_pkg::IDX_POLARITY: rdata_d = {16'h0000, pol_q};
        origin_cfg_pkg::IDX_INIT_LO:  rdata_d = {16'h0000, init_lo_q};
        origin_cfg_pkg::IDX_INIT_HI:  rdata_d = {16'h0000, init_hi_q};
        origin_cfg_pkg::IDX_CONTROL:  rdata_d = {29'h0000_0000, v2_q, 2'h0};
        origin_cfg_pkg::IDX_STATUS:   rdata_d = {30'h0000_0000, bad_q, run_q};
        default:                      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AVS_READDATA_O <= '0;
    end else if (AVS_READ_I && !ack_q) begin
      AVS_READDATA_O <= rdata_d;
    end
  end

endmodule : origin_search_cfg

//--- tb/origin_search_cfg_properties.sv
// Concurrent checks on the ports of the origin search configuration block.
`timescale 1ns/1ps
module origin_search_cfg_check #(
  parameter int unsigned TICK_CYCLES = origin_cfg_pkg::RATE_TICK_CYCLES
) (
  input wire logic                              CLK_I,
  input wire logic                              ARST_N_I,
  input wire logic [origin_cfg_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
  input wire logic                              AVS_READ_I,
  input wire logic                              AVS_WRITE_I,
  input wire logic [31:0]                       AVS_WRITEDATA_I,
  input wire logic [3:0]                        AVS_BYTEENABLE_I,
  input wire logic [31:0]                       AVS_READDATA_O,
  input wire logic                              AVS_WAITREQUEST_O,
  input wire logic                              LIMIT_IN_I,
  input wire logic                              PROX_IN_I,
  input wire logic                              ORIGIN_IN_I,
  input wire logic                              LIMIT_ACTIVE_O,
  input wire logic                              PROX_ACTIVE_O,
  input wire logic                              ORIGIN_ACTIVE_O,
  input wire logic [31:0]                       FREQ_O,
  input wire logic [31:0]                       COMPENSATION_O,
  input wire logic                              RUNNING_O
);
  logic req;
  logic mapped;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  assign req    = AVS_READ_I || AVS_WRITE_I;
  assign mapped = (AVS_ADDRESS_I[1:0] == 2'h0) &&
                  (AVS_ADDRESS_I[11:2] inside {[10'h114:10'h115], [10'h118:10'h11e], [10'h120:10'h121]});

  sequence req_open_s;
    req && !$past(req);
  endsequence
  sequence req_wait_s;
    req && AVS_WAITREQUEST_O;
  endsequence

  first_wait_a: assert property (req_open_s |-> AVS_WAITREQUEST_O)
    else $error("no wait in first request cycle");
  wait_len_a: assert property (req_wait_s |=> !AVS_WAITREQUEST_O)
    else $error("wait lasts beyond one cycle");
  read_upper_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:16] == 16'h0000)
    else $error("upper read half not zero");
  unmapped_zero_a: assert property (AVS_READ_I && !AVS_WAITREQUEST_O && !mapped |-> AVS_READDATA_O == 32'h0)
    else $error("unmapped read not zero");
  comp_latch_a: assert property ($changed(COMPENSATION_O) |-> $rose(RUNNING_O))
    else $error("compensation moved outside start");
  idle_freq_a: assert property (!RUNNING_O |-> FREQ_O == 32'h0)
    else $error("frequency while idle");
  tick_step_a: assert property (RUNNING_O && $past(RUNNING_O) && $changed(FREQ_O) |=> $stable(FREQ_O) [*8])
    else $error("frequency stepped between ticks");
  limit_flag_a: assert property ($changed(LIMIT_IN_I) && !$rose(RUNNING_O) |=> $changed(LIMIT_ACTIVE_O))
    else $error("limit flag ignores input");
  prox_flag_a: assert property ($changed(PROX_IN_I) && !$rose(RUNNING_O) |=> $changed(PROX_ACTIVE_O))
    else $error("proximity flag ignores input");
  origin_flag_a: assert property ($changed(ORIGIN_IN_I) && !$rose(RUNNING_O) |=> $changed(ORIGIN_ACTIVE_O))
    else $error("origin flag ignores input");
endmodule : origin_search_cfg_check

bind origin_search_cfg origin_search_cfg_check #(.TICK_CYCLES(TICK_CYCLES)) origin_search_cfg_check_inst (
  .CLK_I, .ARST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .LIMIT_IN_I, .PROX_IN_I, .ORIGIN_IN_I, .LIMIT_ACTIVE_O,
  .PROX_ACTIVE_O, .ORIGIN_ACTIVE_O, .FREQ_O, .COMPENSATION_O, .RUNNING_O);

//--- tb/origin_sensor_model.sv
// Behavioural model of the limit, proximity and origin switches wired to the block.
`timescale 1ns/1ps
module origin_sensor_model (
  input  wire origin_cfg_pkg::sensor_t present_i,
  input  wire origin_cfg_pkg::sensor_t open_type_i,
  output origin_cfg_pkg::sensor_t      raw_o
);
  // An open-type switch conducts only with the target present; a closed type breaks then.
  assign raw_o.limit  = open_type_i.limit  ? present_i.limit  : !present_i.limit;
  assign raw_o.prox   = open_type_i.prox   ? present_i.prox   : !present_i.prox;
  assign raw_o.origin = open_type_i.origin ? present_i.origin : !present_i.origin;
endmodule : origin_sensor_model

//--- tb/origin_search_cfg_bench.sv
// Self-checking bench of the origin search configuration block.
`timescale 1ns/1ps
module origin_search_cfg_bench;
  localparam int unsigned TICK = 10;
  logic                    clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic [11:0]             addr;
  logic                    rd;
  logic                    wr;
  logic [31:0]             wdata;
  logic [31:0]             rdata;
  logic                    waitreq;
  logic [2:0]              act;
  logic                    running;
  logic [31:0]             freq;
  logic [31:0]             comp;
  origin_cfg_pkg::sensor_t present;
  origin_cfg_pkg::sensor_t open_type;
  origin_cfg_pkg::sensor_t raw;
  int                      err_count = 0;
  int                      n_checks = 0;
  int                      cycles = 0;
  logic [15:0]             vals [7] = '{16'h86a0, 16'h0001, 16'h0000, 16'h8000, 16'hffff, 16'h07d0, 16'h0111};

  origin_search_cfg #(.TICK_CYCLES(TICK)) origin_search_cfg_inst (
    .CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .LIMIT_IN_I(raw.limit), .PROX_IN_I(raw.prox), .ORIGIN_IN_I(raw.origin), .LIMIT_ACTIVE_O(act[2]),
    .PROX_ACTIVE_O(act[1]), .ORIGIN_ACTIVE_O(act[0]), .FREQ_O(freq), .COMPENSATION_O(comp),
    .RUNNING_O(running));
  origin_sensor_model origin_sensor_model_inst (.present_i(present), .open_type_i(open_type), .raw_o(raw));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [11:0] ba(input logic [9:0] ix);
    return {ix, 2'b00};
  endfunction : ba

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [9:0] ix, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ba(ix), d, q);
  endtask : wreg

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : rchk

  task automatic wait_freq(input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    while (freq !== exp && n < 60) begin
      @(negedge clk);
      n++;
    end
    check(freq, exp);
  endtask : wait_freq

  task automatic s_reset();
    repeat (2) @(negedge clk);
    check(freq, 32'h0);
    check({31'h0, running}, 32'h0);
    rchk(ba(origin_cfg_pkg::IDX_PROX_LO), 32'h0);
    rchk(ba(origin_cfg_pkg::IDX_PROX_HI), 32'h0);
    rchk(ba(origin_cfg_pkg::IDX_POLARITY), 32'h0);
    @(posedge clk);
    present <= 3'b111;
    repeat (3) @(negedge clk);
    check({29'h0, act}, 32'h7);
    @(posedge clk);
    present <= 3'b000;
  endtask : s_reset

  task automatic s_regs();
    logic [31:0] q;
    for (int i = 0; i < 7; i++) begin
      wreg(origin_cfg_pkg::IDX_PROX_LO + 10'(i), {16'hdead, vals[i]});
    end
    for (int i = 0; i < 7; i++) begin
      rchk(ba(origin_cfg_pkg::IDX_PROX_LO + 10'(i)), {16'h0, vals[i]});
    end
    bus(1'b1, 12'hffc, 32'h5, q);
    rchk(12'hffc, 32'h0);
    bus(1'b1, ba(origin_cfg_pkg::IDX_PROX_LO) | 12'h2, 32'h5, q);
    rchk(ba(origin_cfg_pkg::IDX_PROX_LO) | 12'h2, 32'h0);
    rchk(ba(origin_cfg_pkg::IDX_PROX_LO), 32'h86a0);
  endtask : s_regs

  task automatic s_profile();
    wreg(origin_cfg_pkg::IDX_INIT_LO, 32'h64);
    wreg(origin_cfg_pkg::IDX_PROX_LO, 32'h82);
    wreg(origin_cfg_pkg::IDX_PROX_HI, 32'h0);
    wreg(origin_cfg_pkg::IDX_ACCEL, 32'h14);
    wreg(origin_cfg_pkg::IDX_DECEL, 32'hf);
    wreg(origin_cfg_pkg::IDX_POLARITY, 32'h101);
    open_type <= 3'b101;
    wreg(origin_cfg_pkg::IDX_CONTROL, 32'h1);
    wait_freq(32'd100);
    check(comp, 32'h8000_0000);
    wreg(origin_cfg_pkg::IDX_COMP_HI, 32'h1);
    wait_freq(32'd120);
    wait_freq(32'd130);
    check(comp, 32'h8000_0000);
    @(posedge clk);
    present <= 3'b111;
    repeat (3) @(negedge clk);
    check({29'h0, act}, 32'h7);
    wreg(origin_cfg_pkg::IDX_CONTROL, 32'h2);
    wait_freq(32'd115);
    wait_freq(32'd0);
    check({31'h0, running}, 32'h0);
  endtask : s_profile

  task automatic try_start(input logic [31:0] prox, input logic [15:0] acc, input logic [2:0] ctl,
                           input logic [1:0] st);
    wreg(origin_cfg_pkg::IDX_PROX_LO, {16'h0, prox[15:0]});
    wreg(origin_cfg_pkg::IDX_PROX_HI, {16'h0, prox[31:16]});
    wreg(origin_cfg_pkg::IDX_ACCEL, {16'h0, acc});
    wreg(origin_cfg_pkg::IDX_CONTROL, {29'h0, ctl[2], 2'b00});
    wreg(origin_cfg_pkg::IDX_CONTROL, {29'h0, ctl});
    rchk(ba(origin_cfg_pkg::IDX_STATUS), {30'h0, st});
    if (st[0]) begin
      wreg(origin_cfg_pkg::IDX_CONTROL, {29'h0, ctl[2], 2'b10});
      wait_freq(32'h0);
    end
  endtask : try_start

  initial begin
    rd        = 1'b0;
    wr        = 1'b0;
    addr      = 12'h0;
    wdata     = 32'h0;
    present   = 3'b000;
    open_type = 3'b000;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    s_reset();
    s_regs();
    s_profile();
    try_start(32'h0, 16'h14, 3'b001, 2'b10);
    try_start(32'h186a1, 16'h14, 3'b001, 2'b10);
    try_start(32'h82, 16'h7d1, 3'b001, 2'b10);
    try_start(32'h82, 16'h7d1, 3'b101, 2'b01);
    final_report();
  end
endmodule : origin_search_cfg_bench
